//--- hw/i2c_rd_slave.sv
/*
 Two-wire slave read path: pointer load, repeated start, one data byte out.
 Assumes SCL and SDA come from pins and are synchronised here; the pad
 resolves the open-drain wire from sda_oe_n_o.
*/
`timescale 1ns/1ps
// Functional notes
// - Address is 1010 plus three pins
// - All bytes shift MSB first
// - Slave acks matching address byte
// - Pointer byte received and acknowledged
// - Pointer holds until reset or rewrite
// - Slave shifts out selected register byte
// - Slave never drives SCL
// - SDA changes only while SCL low
// - Works at 100 and 400 kHz
module i2c_rd_slave (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [2:0] addr_pin_i,
   input wire logic reg_we_i,
   input wire logic [7:0] reg_waddr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic [7:0] pointer_o
);
   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic scl_d;
      logic sda_d;
      logic [2:0] pins_meta;
      logic [2:0] pins;
      i2c_rd_pkg::phase_e phase;
      logic got8;
      logic [2:0] bitn;
      logic [7:0] shift;
      logic rw;
      logic [7:0] ptr;
      i2c_rd_pkg::sda_drv_s drv;
   } state_s;

   state_s s_reg;
   state_s s_next;
   logic [7:0] rdata;
   i2c_rd_pkg::rd_req_s req;

   // Address match on the received byte: four prefix bits and three pin bits
   function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] p);
      addr_hit = (b[7:4] == i2c_rd_pkg::ADDR_PREFIX) && (b[3:1] == p);
   endfunction

   assign req.addr = s_reg.ptr;

   i2c_rd_regfile u_regs (
      .clk_i(clk_i),
      .we_i(reg_we_i),
      .waddr_i(reg_waddr_i),
      .wdata_i(reg_wdata_i),
      .req_i(req),
      .rdata_o(rdata)
   );

   // Edge and condition detection on synchronised pins
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl_s = s_reg.scl_sync[1];
   assign sda_s = s_reg.sda_sync[1];
   assign scl_rise = scl_s && !s_reg.scl_d;
   assign scl_fall = !scl_s && s_reg.scl_d;
   assign start_c = scl_s && s_reg.scl_d && s_reg.sda_d && !sda_s;
   assign stop_c = scl_s && s_reg.scl_d && !s_reg.sda_d && sda_s;

   // Protocol engine; samples on SCL rise, changes SDA on SCL fall
   always_comb
   begin
      s_next = s_reg;
      s_next.scl_sync = {s_reg.scl_sync[0], scl_i};
      s_next.sda_sync = {s_reg.sda_sync[0], sda_i};
      s_next.scl_d = scl_s;
      s_next.sda_d = sda_s;
      s_next.pins_meta = addr_pin_i; // Strap pins cross in through two flops
      s_next.pins = s_reg.pins_meta;
      if (start_c)
      begin
         s_next.phase = i2c_rd_pkg::ST_ADDR;
         s_next.got8 = 1'b0; // The SCL fall that ends a start carries no bit
         s_next.bitn = i2c_rd_pkg::BIT_MSB;
         s_next.drv.sda_oe_n = 1'b1;
      end
      else if (stop_c)
      begin
         s_next.phase = i2c_rd_pkg::ST_IDLE;
         s_next.drv.sda_oe_n = 1'b1;
      end
      else
      begin
         unique case (s_reg.phase)
            i2c_rd_pkg::ST_IDLE, i2c_rd_pkg::ST_SKIP:
            begin
               s_next.drv.sda_oe_n = 1'b1;
            end
            i2c_rd_pkg::ST_ADDR, i2c_rd_pkg::ST_PTR:
            begin
               if (scl_rise)
               begin
                  s_next.shift = {s_reg.shift[6:0], sda_s};
                  s_next.bitn = s_reg.bitn - 3'h1;
                  s_next.got8 = (s_reg.bitn == 3'h0);
               end
               // Judge the byte only after eight rises, never on a stale shift
               else if (scl_fall && s_reg.got8)
               begin
                  s_next.got8 = 1'b0;
                  if (s_reg.phase == i2c_rd_pkg::ST_PTR)
                  begin
                     s_next.ptr = s_reg.shift;
                     s_next.phase = i2c_rd_pkg::ST_PACK;
                     s_next.drv.sda_oe_n = 1'b0;
                  end
                  else if (addr_hit(s_reg.shift, s_reg.pins))
                  begin
                     s_next.rw = s_reg.shift[0];
                     s_next.phase = i2c_rd_pkg::ST_AACK;
                     s_next.drv.sda_oe_n = 1'b0;
                  end
                  else
                  begin
                     s_next.phase = i2c_rd_pkg::ST_SKIP;
                  end
               end
            end
            i2c_rd_pkg::ST_AACK, i2c_rd_pkg::ST_PACK:
            begin
               // Ack held across the full high phase; next fall frees it, or on a read drives rdata[7]
               if (scl_fall)
               begin
                  s_next.bitn = i2c_rd_pkg::BIT_MSB;
                  if (s_reg.phase == i2c_rd_pkg::ST_AACK && s_reg.rw)
                  begin
                     s_next.phase = i2c_rd_pkg::ST_DATA;
                     s_next.shift = {rdata[6:0], 1'b0};
                     s_next.drv.sda_oe_n = rdata[7];
                  end
                  else if (s_reg.phase == i2c_rd_pkg::ST_AACK)
                  begin
                     s_next.phase = i2c_rd_pkg::ST_PTR;
                     s_next.drv.sda_oe_n = 1'b1;
                  end
                  else
                  begin
                     s_next.phase = i2c_rd_pkg::ST_SKIP; // Writes of data not handled here
                     s_next.drv.sda_oe_n = 1'b1;
                  end
               end
            end
            i2c_rd_pkg::ST_DATA:
            begin
               if (scl_fall)
               begin
                  s_next.bitn = s_reg.bitn - 3'h1;
                  if (s_reg.bitn == 3'h0)
                  begin
                     s_next.phase = i2c_rd_pkg::ST_MACK;
                     s_next.drv.sda_oe_n = 1'b1;
                  end
                  else
                  begin
                     s_next.drv.sda_oe_n = s_reg.shift[7];
                     s_next.shift = {s_reg.shift[6:0], 1'b0};
                  end
               end
            end
            i2c_rd_pkg::ST_MACK:
            begin
               // Single byte per read; wait for stop or repeated start
               if (scl_rise)
               begin
                  s_next.phase = i2c_rd_pkg::ST_SKIP;
               end
            end
         endcase
      end
      if (srst_i)
      begin
         s_next.phase = i2c_rd_pkg::ST_IDLE;
         s_next.ptr = i2c_rd_pkg::PTR_RESET;
         s_next.drv.sda_oe_n = 1'b1;
         s_next.drv.sda_o = 1'b0;
         s_next.bitn = i2c_rd_pkg::BIT_MSB;
         s_next.shift = 8'h00;
         s_next.rw = 1'b0;
         s_next.got8 = 1'b0;
         s_next.scl_sync = 2'h3;
         s_next.sda_sync = 2'h3;
         s_next.scl_d = 1'b1;
         s_next.sda_d = 1'b1;
      end
   end

   // Single state register; all outputs come from it
   always_ff @(posedge clk_i)
   begin
      s_reg <= s_next;
   end

   // SDA is only ever pulled low; SCL has no driver at all
   assign sda_o = s_reg.drv.sda_o;
   assign sda_oe_n_o = s_reg.drv.sda_oe_n;
   assign pointer_o = s_reg.ptr;

   chk_ack_low_drive: assert property (@(posedge clk_i) disable iff (srst_i)
      (s_reg.phase == i2c_rd_pkg::ST_AACK) |-> !sda_oe_n_o)
      else $error("address ack not driven");
   chk_idle_release: assert property (@(posedge clk_i) disable iff (srst_i)
      (s_reg.phase inside {i2c_rd_pkg::ST_IDLE, i2c_rd_pkg::ST_SKIP}) |=> sda_oe_n_o)
      else $error("sda driven outside ack or data");
   chk_pointer_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      (s_reg.phase != i2c_rd_pkg::ST_PTR) |=> $stable(pointer_o))
      else $error("pointer changed outside pointer phase");
   chk_sda_on_low: assert property (@(posedge clk_i) disable iff (srst_i)
      $changed(sda_oe_n_o) && !$past(start_c) && !$past(stop_c) |-> !s_reg.scl_d)
      else $error("sda moved while scl high");
   chk_miss_ignore: assert property (@(posedge clk_i) disable iff (srst_i)
      (s_reg.phase == i2c_rd_pkg::ST_SKIP) |-> sda_oe_n_o && $stable(pointer_o))
      else $error("unmatched address disturbed state");
   chk_ptr_ack: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(s_reg.phase == i2c_rd_pkg::ST_PACK) |-> !sda_oe_n_o && pointer_o == $past(s_reg.shift))
      else $error("pointer byte not loaded and acked");
   chk_data_msb: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(s_reg.phase == i2c_rd_pkg::ST_DATA) |-> sda_oe_n_o == $past(rdata[7]))
      else $error("first data bit not register msb");
   chk_master_ack: assert property (@(posedge clk_i) disable iff (srst_i)
      (s_reg.phase == i2c_rd_pkg::ST_MACK) |-> sda_oe_n_o)
      else $error("slave drove during master ack");
   chk_full_byte: assert property (@(posedge clk_i) disable iff (srst_i)
      $rose(s_reg.phase == i2c_rd_pkg::ST_AACK) |-> $past(s_reg.got8))
      else $error("address judged before eight bits");
endmodule

//--- pkg/i2c_rd_pkg.sv
/*
 Shared constants and carrier types for the two-wire register read slave.
 Assumes a 100 MHz system clock sampling the serial pins.
*/
package i2c_rd_pkg;
   localparam logic [3:0] ADDR_PREFIX = 4'ha;
   localparam int CLK_PERIOD_NS = 10;
   localparam int FAST_SCL_HZ = 400000;
   localparam int STD_SCL_HZ = 100000;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [2:0] BIT_MSB = 3'h7;
   // Shortest fast-mode SCL low half, in cycles; sampling must beat it
   localparam int SCL_LOW_NS = 1300;
   localparam int SCL_LOW_CYC = SCL_LOW_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_AACK = 3'h3,
      ST_PTR = 3'h2,
      ST_PACK = 3'h6,
      ST_DATA = 3'h7,
      ST_MACK = 3'h5,
      ST_SKIP = 3'h4
   } phase_e;

   // Register file read port
   typedef struct packed {
      logic [7:0] addr;
   } rd_req_s;

   // Open-drain data pin drive
   typedef struct packed {
      logic sda_o;
      logic sda_oe_n;
   } sda_drv_s;
endpackage

//--- hw/i2c_rd_regfile.sv
/*
 Small register memory: 256 bytes with registered read data.
 Assumes the write port is driven by the device's configuration logic.
*/
`timescale 1ns/1ps
module i2c_rd_regfile (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [7:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire i2c_rd_pkg::rd_req_s req_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [0:255];

   // Read data from a flop keeps the path to the shifter short
   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[req_i.addr];
   end
endmodule

//--- verification/i2c_master_model.sv
/*
 Two-wire bus master model: start, stop, byte send and byte receive.
 Assumes the bench resolves the open-drain SDA wire with a pull-up.
*/
`timescale 1ns/1ps
module i2c_master_model (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o
);
   // Bus idles released, clock high between frames
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // Data moves 20 ns into SCL low, never while SCL is high
   task automatic bit_out(input logic b);
   begin
      #20 sda_pull_o = ~b;
      #42.5 scl_o = 1'b1;
      #62.5 scl_o = 1'b0;
   end
   endtask
   // Sampled mid-high, well after the slave's late data change
   task automatic bit_in(output logic b);
   begin
      #20 sda_pull_o = 1'b0;
      #42.5 scl_o = 1'b1;
      #31.25 b = sda_i;
      #31.25 scl_o = 1'b0;
   end
   endtask
   // Start and repeated start: SDA up, SCL up, then SDA down
   task automatic start();
   begin
      #20 sda_pull_o = 1'b0;
      #42.5 scl_o = 1'b1;
      #62.5 sda_pull_o = 1'b1;
      #62.5 scl_o = 1'b0;
   end
   endtask
   task automatic stop();
   begin
      #20 sda_pull_o = 1'b1;
      #42.5 scl_o = 1'b1;
      #62.5 sda_pull_o = 1'b0;
      #62.5;
   end
   endtask
   // Ack is SDA low in the ninth bit
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic b;
   begin
      for (int i = 7; i >= 0; i--)
         bit_out(d[i]);
      bit_in(b);
      ack = ~b;
   end
   endtask
   task automatic recv_byte(output logic [7:0] d, input logic ack);
      logic b;
   begin
      for (int i = 7; i >= 0; i--)
      begin
         bit_in(b);
         d[i] = b;
      end
      bit_out(~ack);
   end
   endtask
endmodule

//--- verification/tb_i2c_slave_register_read.sv
/*
 Bench for the two-wire register read slave: pointer loads, reads,
 foreign addresses and reset. Assumes the slave holds the memory.
*/
`timescale 1ns/1ps
module tb_i2c_slave_register_read;
   logic clk_i;
   logic srst_i = 1'b1;
   logic [2:0] addr_pin_i = 3'h0;
   logic reg_we_i = 1'b0;
   logic [7:0] reg_waddr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic sda_o, sda_oe_n_o, m_scl, m_pull, oe_prev, drove;
   logic [7:0] pointer_o;
   logic [7:0] mem [256];
   wire sda = ~(m_pull | (~sda_oe_n_o & ~sda_o)); // Pull-up wire
   int err_total = 0;
   int compares = 0;

   i2c_rd_slave i_dut (.clk_i, .srst_i, .scl_i(m_scl), .sda_i(sda), .addr_pin_i,
      .reg_we_i, .reg_waddr_i, .reg_wdata_i, .sda_o, .sda_oe_n_o, .pointer_o);
   i2c_master_model i_mst (.sda_i(sda), .scl_o(m_scl), .sda_pull_o(m_pull));

   // 100 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
   begin
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   task automatic conclude();
   begin
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // Slave drive edges must land in SCL low time
   always @(posedge clk_i)
   begin
      if (sda_oe_n_o !== oe_prev && !srst_i)
         check({7'h00, m_scl}, 8'h00);
      if (sda_oe_n_o === 1'b0)
         drove <= 1'b1;
      oe_prev <= sda_oe_n_o;
   end
   // Optional pointer phase, then repeated start and one read
   task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic wr,
      output logic [7:0] d, output logic ak);
      logic a1, a2, a3;
   begin
      d = 8'h00;
      a1 = 1'b1;
      a2 = 1'b1;
      i_mst.start();
      if (wr)
      begin
         i_mst.send_byte({a, 1'b0}, a1);
         i_mst.send_byte(p, a2);
         i_mst.start();
      end
      i_mst.send_byte({a, 1'b1}, a3);
      if (a3)
         i_mst.recv_byte(d, 1'b1);
      i_mst.stop();
      ak = a1 & a2 & a3;
   end
   endtask
   // Hang guard
   initial
   begin
      repeat (90000) @(posedge clk_i);
      err_total++;
      conclude();
   end
   initial
   begin
      logic [7:0] d, p;
      logic [6:0] own;
      logic ak;
      d = 8'($urandom(32'h039a));
      addr_pin_i = 3'($urandom);
      repeat (20) @(negedge clk_i);
      srst_i = 1'b0;
      // Memory has no reset, so load it all first
      for (int i = 0; i < 256; i++)
      begin
         @(negedge clk_i);
         reg_we_i = 1'b1;
         reg_waddr_i = 8'(i);
         reg_wdata_i = 8'($urandom);
         mem[i] = reg_wdata_i;
      end
      @(negedge clk_i);
      reg_we_i = 1'b0;
      check(pointer_o, 8'h00);
      check({7'h00, sda_oe_n_o}, 8'h01);
      check({7'h00, sda_o}, 8'h00);
      own = {4'ha, addr_pin_i};
      // Edge pointers then random ones, each read twice
      for (int i = 0; i < 10; i++)
      begin
         p = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         xfer(own, p, 1'b1, d, ak);
         check({7'h00, ak}, 8'h01);
         check(pointer_o, p);
         check(d, mem[p]);
         xfer(own, 8'h00, 1'b0, d, ak);
         check(d, mem[p]);
      end
      // One low bit off, then a wrong prefix
      for (int i = 0; i < 2; i++)
      begin
         drove = 1'b0;
         xfer((i == 0) ? own ^ 7'h01 : {4'h5, own[2:0]}, ~p, 1'b1, d, ak);
         check({7'h00, ak}, 8'h00);
         check(pointer_o, p);
         check({7'h00, drove}, 8'h00);
      end
      // Pins move the address while idle
      @(negedge clk_i);
      addr_pin_i = ~addr_pin_i;
      own = {4'ha, addr_pin_i};
      repeat (4) @(negedge clk_i);
      xfer(own, 8'h5a, 1'b1, d, ak);
      check({7'h00, ak}, 8'h01);
      check(d, mem[8'h5a]);
      // Mid-run reset clears the pointer
      @(negedge clk_i);
      srst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      check(pointer_o, 8'h00);
      xfer(own, 8'h00, 1'b0, d, ak);
      check(d, mem[8'h00]);
      conclude();
   end
endmodule
